// >>> pkg/msd_pkg.sv
// Package of constants and types for the memory select decode block.
`default_nettype none
package msd_pkg;

    // Decode array geometry.
    localparam int NUM_PRIMARY = 8;
    localparam int NUM_BOOT = 4;
    localparam int NUM_PERIPH = 2;
    localparam int TERMS_PER_SEL = 3;
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 8;
    localparam int DEC_W = ADDR_W + PAGE_W;
    localparam int IN_BUS_W = 82;

    // Select indices inside the flat select vector.
    localparam int SEL_PRIM_BASE = 0;
    localparam int SEL_BOOT_BASE = SEL_PRIM_BASE + NUM_PRIMARY;
    localparam int SEL_SRAM = SEL_BOOT_BASE + NUM_BOOT;
    localparam int SEL_CFG = SEL_SRAM + 1;
    localparam int SEL_TEST = SEL_CFG + 1;
    localparam int SEL_PERIPH_BASE = SEL_TEST + 1;
    localparam int NUM_SEL = SEL_PERIPH_BASE + NUM_PERIPH;

    // Offsets inside the configuration I/O space.
    localparam logic [7:0] OFS_PAGE = 8'hE0;
    localparam logic [7:0] OFS_SPACE_MAP = 8'hC2;
    localparam logic [7:0] OFS_PM0 = 8'hB0;
    localparam logic [7:0] OFS_PM2 = 8'hB4;
    localparam logic [7:0] OFS_MEMCFG_A = 8'hF0;
    localparam logic [7:0] OFS_MEMCFG_B = 8'hF1;

    // Space-map field positions.
    localparam int SM_SRAM_PROG = 0;
    localparam int SM_BOOT_PROG = 1;
    localparam int SM_PRIM_PROG = 2;
    localparam int SM_BOOT_DATA = 3;
    localparam int SM_PRIM_DATA = 4;

    // Power mode field positions.
    localparam int PM0_FAST_BIT = 3;
    localparam int PM2_BLK_WR = 0;
    localparam int PM2_BLK_RD = 1;
    localparam int PM2_BLK_FETCH = 2;
    localparam int PM2_BLK_RST = 3;
    localparam int PM2_BLK_PDN = 4;

    // Values after reset.
    localparam logic [7:0] SPACE_MAP_INIT = 8'h0C;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] PM0_RESET = 8'h08;
    localparam logic [7:0] PM2_RESET = 8'h00;
    localparam logic [7:0] DOUT_RESET = 8'h00;
    // Memory configuration words; the values are arbitrary.
    localparam logic [7:0] MEMCFG_A_VALUE = 8'h5A;
    localparam logic [7:0] MEMCFG_B_VALUE = 8'hA5;

    // Standby timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int STANDBY_NS = 70;
    localparam logic [3:0] STANDBY_CYCLES =
        4'((STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // One product term: hit when en is set and (vector & mask) == match.
    typedef struct packed {
        logic en;
        logic [DEC_W-1:0] mask;
        logic [DEC_W-1:0] match;
    } msd_term_t;

    typedef msd_term_t [TERMS_PER_SEL-1:0] msd_sel_terms_t;
    typedef msd_sel_terms_t [NUM_SEL-1:0] msd_term_table_t;

    // Vector layout is {page, address}.
    function automatic msd_term_table_t msd_default_terms();
        msd_term_table_t t;
        t = '0;
        t[SEL_PRIM_BASE][0] = '{1'b1, 24'h00C000, 24'h008000};
        t[SEL_PRIM_BASE + 1][0] = '{1'b1, 24'h00C000, 24'h00C000};
        t[SEL_BOOT_BASE][0] = '{1'b1, 24'h00E000, 24'h008000};
        t[SEL_BOOT_BASE + 1][0] = '{1'b1, 24'h00E000, 24'h000000};
        t[SEL_SRAM][0] = '{1'b1, 24'h00F800, 24'h008000};
        t[SEL_CFG][0] = '{1'b1, 24'h00FF00, 24'h00B000};
        return t;
    endfunction : msd_default_terms

endpackage : msd_pkg
`default_nettype wire

// >>> logic/msd_term_match.sv
// One decode-array select: an OR of up to three product terms.
`timescale 1ns/1ps
`default_nettype none
module msd_term_match
    import msd_pkg::*;
(
    // Decode vector and programmed terms.
    input wire logic [DEC_W-1:0] vec,
    input wire msd_sel_terms_t terms,
    // Result.
    output logic hit
);
    logic [TERMS_PER_SEL-1:0] term_hit;

    genvar g;
    generate
        for (g = 0; g < TERMS_PER_SEL; g++) begin : g_term
            assign term_hit[g] = terms[g].en && ((vec & terms[g].mask) == terms[g].match);
        end
    endgenerate

    assign hit = |term_hit;
endmodule : msd_term_match
`default_nettype wire

// >>> logic/msd_memory_select_decode.sv
// Memory select decode: priority resolve, space mapping, page and mode registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - Overlapping selects resolved by level; level 1 wins, level 3 loses.
// R2 - Software never maps two same-level selects over the same addresses.
// R3 - An address inside the SRAM range always goes to SRAM; the code does not select SRAM for a fetch while space map bit 0 is clear.
// R4 - Boot sector range outside SRAM wins over primary flash sectors.
// R5 - Each memory sits in program space, data space or both per space map; the code always keeps SRAM in data space, whatever the map says.
// R6 - Space map loads its initial value at boot; MCU rewrites take effect at once.
// R7 - Space map 0Ch: fetch reaches primary, read reaches boot, SRAM, I/O.
// R8 - Space map bits 2 and 4 set: primary reachable by fetch or read.
// R9 - Eight-bit page register at offset E0h, read and written over D0-D7.
// R10 - Page bits feed the decode array to extend addressing by 256 pages.
// R11 - Page bits are also passed to the general logic array.
// R12 - Two read-only memory configuration words readable in config space.
// R13 - Fast-response bit 3 of power mode zero clear: standby after 70ns idle.
// R14 - Five power mode two bits each block one control input from the arrays.
// R15 - The arrays get an 82-signal input bus.
// R16 - Extended address mode decodes A19-A4 instead of A15-A0.
// R17 - Primary selects and four boot selects, each up to three product terms.
// R18 - Also SRAM, config space, test-port enable and two peripheral selects.
// R19 - Decode and logic functions are live as soon as reset ends.
// R20 - SRAM answers only while its select is high; up to three terms.
// R21 - Page and space map reads return the last write or the initial value.
// R22 - Selects follow the current address, strobes and page bits each cycle.
module msd_memory_select_decode
    import msd_pkg::*;
#(
    parameter msd_term_table_t TERMS = msd_default_terms()
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Microcontroller bus.
    input wire logic [19:0] addr,
    input wire logic bus_control_line_zero_n,
    input wire logic bus_control_line_one_n,
    input wire logic program_fetch_strobe_n,
    input wire logic ext_addr_mode,
    input wire logic [7:0] d_in,
    output logic [7:0] d_out,
    output logic d_oe,
    // Other array inputs.
    input wire logic power_down_input,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_c_in,
    input wire logic [3:0] port_d_in,
    input wire logic [7:0] port_f_in,
    input wire logic [7:0] mcell_a_fb,
    input wire logic [7:0] mcell_b_fb,
    input wire logic flash_ready,
    // Memory selects.
    output logic [NUM_PRIMARY-1:0] primary_sector_select,
    output logic [NUM_BOOT-1:0] boot_sector_select,
    output logic sram_select,
    output logic config_io_select,
    output logic test_port_enable,
    output logic [NUM_PERIPH-1:0] periph_select,
    // General logic array feed and power state.
    output logic [IN_BUS_W-1:0] array_input_bus,
    output logic [7:0] page_bits,
    output logic array_standby
);

    typedef struct packed {
        logic [7:0] page;
        logic [7:0] space_map;
        logic [7:0] pm0;
        logic [7:0] pm2;
        logic [7:0] dout;
        logic doe;
        logic wr_prev;
        logic [3:0] idle_cnt;
        logic standby;
        logic [IN_BUS_W-1:0] prev_bus;
        logic [IN_BUS_W-1:0] bus;
        logic [NUM_SEL-1:0] sel;
    } msd_state_t;

    msd_state_t state_r;
    msd_state_t state_nxt;

    localparam msd_state_t STATE_RESET = '{
        page: PAGE_RESET,
        space_map: SPACE_MAP_INIT,
        pm0: PM0_RESET,
        pm2: PM2_RESET,
        dout: DOUT_RESET,
        doe: 1'b0,
        wr_prev: 1'b1,
        idle_cnt: 4'h0,
        standby: 1'b0,
        prev_bus: '0,
        bus: '0,
        sel: '0
    };

    // Register read decoder, used for the data bus answer.
    function automatic logic [7:0] msd_reg_read(input logic [7:0] ofs, input msd_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (ofs)
            OFS_PAGE: v = s.page; // [R9] [R21]
            OFS_SPACE_MAP: v = s.space_map; // [R21]
            OFS_PM0: v = s.pm0;
            OFS_PM2: v = s.pm2;
            OFS_MEMCFG_A: v = MEMCFG_A_VALUE; // [R12]
            OFS_MEMCFG_B: v = MEMCFG_B_VALUE; // [R12]
            default: v = 8'h00;
        endcase
        return v;
    endfunction : msd_reg_read

    // Decode vector built from the live address and page bits.
    logic [ADDR_W-1:0] dec_addr;
    logic [DEC_W-1:0] dec_vec;
    logic [NUM_SEL-1:0] raw_sel;

    assign dec_addr = ext_addr_mode ? addr[19:4] : addr[15:0]; // [R16]
    assign dec_vec = {state_r.page, dec_addr}; // [R10]

    genvar s;
    generate
        for (s = 0; s < NUM_SEL; s++) begin : g_sel
            // Every select, SRAM included, is an OR of up to three terms.
            msd_term_match u_match ( // [R17] [R18] [R20]
                .vec(dec_vec),
                .terms(TERMS[s]),
                .hit(raw_sel[s])
            );
        end
    endgenerate

    // Control signals after the blocking mask.
    logic wr_in;
    logic rd_in;
    logic fetch_in;
    logic rst_in;
    logic pdn_in;
    logic [IN_BUS_W-1:0] bus_now;

    always_comb begin
        wr_in = bus_control_line_zero_n;
        rd_in = bus_control_line_one_n;
        fetch_in = program_fetch_strobe_n;
        rst_in = rst;
        pdn_in = power_down_input;
        // A blocked line is held at its idle level so the arrays see no toggling.
        if (state_r.pm2[PM2_BLK_WR]) begin // [R14]
            wr_in = 1'b1;
        end
        if (state_r.pm2[PM2_BLK_RD]) begin // [R14]
            rd_in = 1'b1;
        end
        if (state_r.pm2[PM2_BLK_FETCH]) begin // [R14]
            fetch_in = 1'b1;
        end
        if (state_r.pm2[PM2_BLK_RST]) begin // [R14]
            rst_in = 1'b0;
        end
        if (state_r.pm2[PM2_BLK_PDN]) begin // [R14]
            pdn_in = 1'b0;
        end
        bus_now = {dec_addr, wr_in, rd_in, fetch_in, rst_in, pdn_in,
                   port_a_in, port_b_in, port_c_in, port_d_in, port_f_in,
                   state_r.page, mcell_a_fb, mcell_b_fb, flash_ready}; // [R15] [R11]
    end

    // Priority resolve and space routing.
    logic lvl1_hit;
    logic boot_hit;
    logic fetch_act;
    logic read_act;
    logic write_act;
    logic prim_ok;
    logic boot_ok;
    logic sram_ok;
    logic [NUM_SEL-1:0] sel_now;

    always_comb begin
        fetch_act = ~program_fetch_strobe_n;
        read_act = ~bus_control_line_one_n;
        write_act = ~bus_control_line_zero_n;
        lvl1_hit = raw_sel[SEL_SRAM] | raw_sel[SEL_CFG] |
                   (|raw_sel[SEL_PERIPH_BASE +: NUM_PERIPH]);
        boot_hit = |raw_sel[SEL_BOOT_BASE +: NUM_BOOT];
        // Writes are always data space; fetches follow the space map, and so do reads except for SRAM.
        prim_ok = (fetch_act & state_r.space_map[SM_PRIM_PROG]) |
                  (read_act & state_r.space_map[SM_PRIM_DATA]) | write_act; // [R5] [R7] [R8]
        boot_ok = (fetch_act & state_r.space_map[SM_BOOT_PROG]) |
                  (read_act & state_r.space_map[SM_BOOT_DATA]) | write_act; // [R5] [R7]
        sram_ok = (fetch_act & state_r.space_map[SM_SRAM_PROG]) |
                  read_act | write_act; // [R5] [R7]
        sel_now = raw_sel;
        if (lvl1_hit) begin // [R1] [R3]
            sel_now[SEL_BOOT_BASE +: NUM_BOOT] = '0;
            sel_now[SEL_PRIM_BASE +: NUM_PRIMARY] = '0;
        end else if (boot_hit) begin // [R1] [R4]
            sel_now[SEL_PRIM_BASE +: NUM_PRIMARY] = '0;
        end
        if (!prim_ok) begin
            sel_now[SEL_PRIM_BASE +: NUM_PRIMARY] = '0;
        end
        if (!boot_ok) begin
            sel_now[SEL_BOOT_BASE +: NUM_BOOT] = '0;
        end
        if (!sram_ok) begin // [R20]
            sel_now[SEL_SRAM] = 1'b0;
        end
    end

    // Configuration space access. The space itself is found by its own select.
    logic cfg_hit;
    logic wr_fall;
    logic [7:0] cfg_ofs;

    assign cfg_hit = raw_sel[SEL_CFG];
    assign cfg_ofs = addr[7:0];
    assign wr_fall = state_r.wr_prev & ~bus_control_line_zero_n;

    always_comb begin
        state_nxt = state_r;
        state_nxt.wr_prev = bus_control_line_zero_n;
        state_nxt.sel = sel_now; // [R19] [R22]
        state_nxt.bus = bus_now;
        state_nxt.prev_bus = bus_now;

        // One write per strobe: the falling edge stores, the held level does not.
        if (wr_fall && cfg_hit) begin
            case (cfg_ofs)
                OFS_PAGE: state_nxt.page = d_in; // [R9]
                OFS_SPACE_MAP: state_nxt.space_map = d_in; // [R6]
                OFS_PM0: state_nxt.pm0 = d_in;
                OFS_PM2: state_nxt.pm2 = d_in;
                default: state_nxt.page = state_r.page;
            endcase
        end

        // Reads of mapped and unmapped offsets both drive; unmapped reads give zero.
        if (cfg_hit && read_act) begin
            state_nxt.dout = msd_reg_read(cfg_ofs, state_r); // [R12] [R21]
            state_nxt.doe = 1'b1;
        end else begin
            state_nxt.dout = DOUT_RESET;
            state_nxt.doe = 1'b0;
        end

        // Idle detector. Any change of the array inputs restarts the count.
        if (bus_now != state_r.prev_bus) begin
            state_nxt.idle_cnt = 4'h0;
        end else if (state_r.idle_cnt != STANDBY_CYCLES) begin
            state_nxt.idle_cnt = state_r.idle_cnt + 4'h1;
        end
        state_nxt.standby = ~state_r.pm0[PM0_FAST_BIT] && (bus_now == state_r.prev_bus) &&
                            (state_r.idle_cnt >= STANDBY_CYCLES - 4'h1); // [R13]
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= STATE_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state register.
    assign d_out = state_r.dout;
    assign d_oe = state_r.doe;
    assign primary_sector_select = state_r.sel[SEL_PRIM_BASE +: NUM_PRIMARY];
    assign boot_sector_select = state_r.sel[SEL_BOOT_BASE +: NUM_BOOT];
    assign sram_select = state_r.sel[SEL_SRAM]; // [R3] [R20]
    assign config_io_select = state_r.sel[SEL_CFG];
    assign test_port_enable = state_r.sel[SEL_TEST];
    assign periph_select = state_r.sel[SEL_PERIPH_BASE +: NUM_PERIPH];
    assign array_input_bus = state_r.bus; // [R15]
    assign page_bits = state_r.page; // [R11]
    assign array_standby = state_r.standby; // [R13]

endmodule : msd_memory_select_decode
`default_nettype wire

// >>> sim/msd_mcu_model.sv
// Microcontroller bus model that drives the block from the far side.
`timescale 1ns/1ps
`default_nettype none
module msd_mcu_model (
    // Clock and returned data.
    input wire logic clk,
    input wire logic [7:0] d_out,
    // Bus toward the block.
    output logic [19:0] addr,
    output logic bus_control_line_zero_n,
    output logic bus_control_line_one_n,
    output logic program_fetch_strobe_n,
    output logic ext_addr_mode,
    output logic [7:0] d_in
);
    initial begin
        addr = 20'h04000;
        bus_control_line_zero_n = 1'b1;
        bus_control_line_one_n = 1'b1;
        program_fetch_strobe_n = 1'b1;
        ext_addr_mode = 1'b0;
        d_in = 8'h00;
    end

    // The strobe rises for at least one edge before the next write can start.
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk);
        addr = {4'h0, a};
        ext_addr_mode = 1'b0;
        d_in = v;
        bus_control_line_zero_n = 1'b0;
        @(negedge clk);
        bus_control_line_zero_n = 1'b1;
        // Released data lines carry junk, so a stale byte cannot pass for a good one.
        d_in = ~v;
    endtask : wr

    // Kind 0 only presents the address, 1 reads, 2 fetches.
    task automatic acc(input logic [1:0] k, input logic e, input logic [19:0] a,
        output logic [7:0] q);
        @(negedge clk);
        addr = a;
        ext_addr_mode = e;
        bus_control_line_one_n = (k != 2'h1);
        program_fetch_strobe_n = (k != 2'h2);
        repeat (2) @(posedge clk);
        @(negedge clk);
        q = d_out;
        bus_control_line_one_n = 1'b1;
        program_fetch_strobe_n = 1'b1;
    endtask : acc
endmodule : msd_mcu_model
`default_nettype wire

// >>> sim/msd_asserts.sv
// Port-level assertions for the memory select decode block.
`timescale 1ns/1ps
`default_nettype none
module msd_asserts
    import msd_pkg::*;
(
    // Clock, reset and bus.
    input wire logic clk,
    input wire logic rst,
    input wire logic [19:0] addr,
    input wire logic bus_control_line_zero_n,
    input wire logic bus_control_line_one_n,
    input wire logic program_fetch_strobe_n,
    input wire logic ext_addr_mode,
    input wire logic [7:0] d_in,
    input wire logic [7:0] d_out,
    input wire logic d_oe,
    // Selects and array side.
    input wire logic [NUM_PRIMARY-1:0] primary_sector_select,
    input wire logic [NUM_BOOT-1:0] boot_sector_select,
    input wire logic sram_select,
    input wire logic config_io_select,
    input wire logic [IN_BUS_W-1:0] array_input_bus,
    input wire logic [7:0] page_bits,
    input wire logic array_standby
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic nx;
    assign nx = !ext_addr_mode;

    chk_sram_first: assert property (
        !bus_control_line_one_n && nx && addr[15:11] == 5'h10
        |=> sram_select && !boot_sector_select[0] && primary_sector_select == '0)
        else $error("SRAM range did not select SRAM alone");
    chk_boot_first: assert property (
        !bus_control_line_one_n && nx && addr[15:13] == 3'h4 && addr[15:11] != 5'h10
        |=> boot_sector_select[0] && !primary_sector_select[0])
        else $error("boot range lost to primary");
    chk_fetch_prim: assert property (
        !program_fetch_strobe_n && nx && addr[15:14] == 2'h3 |=> primary_sector_select[1])
        else $error("fetch did not reach primary");
    chk_cfg_level: assert property (
        config_io_select |-> primary_sector_select == '0 && !sram_select)
        else $error("config select shared with memory");
    chk_sram_strobe: assert property (
        sram_select |-> $past(!bus_control_line_one_n || !program_fetch_strobe_n
        || !bus_control_line_zero_n))
        else $error("SRAM selected without strobe");
    chk_page_write: assert property (
        $fell(bus_control_line_zero_n) && nx && addr[15:0] == {8'hB0, OFS_PAGE}
        |=> page_bits == $past(d_in))
        else $error("page write lost");
    chk_page_hold: assert property (
        $changed(page_bits) |-> $past(!bus_control_line_zero_n))
        else $error("page changed without write");
    chk_read_data: assert property (
        !bus_control_line_one_n && bus_control_line_zero_n && nx
        && addr[15:0] == {8'hB0, OFS_PAGE} |=> d_oe && d_out == page_bits)
        else $error("page read data wrong");
    chk_standby_drop: assert property (
        $changed(array_input_bus) |=> !array_standby)
        else $error("standby held across input change");

    cover property (sram_select);
    cover property ($rose(array_standby));
    cover property (config_io_select ##1 !config_io_select);
endmodule : msd_asserts

bind msd_memory_select_decode msd_asserts u_chk (
    .clk, .rst, .addr, .bus_control_line_zero_n, .bus_control_line_one_n,
    .program_fetch_strobe_n, .ext_addr_mode, .d_in, .d_out, .d_oe,
    .primary_sector_select, .boot_sector_select, .sram_select, .config_io_select,
    .array_input_bus, .page_bits, .array_standby
);
`default_nettype wire

// >>> sim/msd_memory_select_decode_test.sv
// Self-checking bench for the memory select decode block.
`timescale 1ns/1ps
`default_nettype none
module msd_memory_select_decode_test
    import msd_pkg::*;
;
    logic clk, rst, wn, rn, fn, ext, oe, sram, cfg, stby, tpe;
    logic [1:0] per;
    logic [19:0] addr;
    logic [7:0] d_in, d_out, pg, q;
    logic [3:0] boot;
    logic [NUM_PRIMARY-1:0] prim;
    logic [81:0] bus;
    logic [53:0] misc;
    int errors, tests_run;

    // The default table plus a paged test-port term and two peripheral terms.
    function automatic msd_term_table_t tb_terms();
        msd_term_table_t t;
        t = msd_default_terms();
        t[SEL_TEST][0] = '{1'b1, 24'hFFFF00, 24'h3CB100};
        t[SEL_PERIPH_BASE][0] = '{1'b1, 24'h00FF00, 24'h00B200};
        t[SEL_PERIPH_BASE + 1][0] = '{1'b1, 24'h00FF00, 24'h00B300};
        return t;
    endfunction : tb_terms

    // The term table keeps same-level ranges apart.
    msd_memory_select_decode #(.TERMS(tb_terms())) u_dut (
        .clk(clk), .rst(rst), .addr(addr), .bus_control_line_zero_n(wn),
        .bus_control_line_one_n(rn), .program_fetch_strobe_n(fn), .ext_addr_mode(ext),
        .d_in(d_in), .d_out(d_out), .d_oe(oe), .power_down_input(misc[53]),
        .port_a_in(misc[52:45]), .port_b_in(misc[44:37]), .port_c_in(misc[36:29]),
        .port_d_in(misc[28:25]), .port_f_in(misc[24:17]), .mcell_a_fb(misc[16:9]),
        .mcell_b_fb(misc[8:1]), .flash_ready(misc[0]), .primary_sector_select(prim),
        .boot_sector_select(boot), .sram_select(sram), .config_io_select(cfg),
        .test_port_enable(tpe), .periph_select(per), .array_input_bus(bus), .page_bits(pg),
        .array_standby(stby)
    );
    msd_mcu_model u_mcu (
        .clk(clk), .d_out(d_out), .addr(addr), .bus_control_line_zero_n(wn),
        .bus_control_line_one_n(rn), .program_fetch_strobe_n(fn), .ext_addr_mode(ext),
        .d_in(d_in)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [81:0] got, input logic [81:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // The reset bit of the array bus is skipped; its polarity is not fixed here.
    task automatic t_bus(input logic [15:0] a, input logic [2:0] s, input logic [7:0] p);
        check({bus[81:63], bus[61:0]}, {a, s, misc[53:17], p, misc[16:0]});
    endtask : t_bus

    task automatic t_reset();
        check(pg, PAGE_RESET);
        u_mcu.acc(2'h1, 1'b0, 20'h08400, q);
        check(sram, 1'b1);
        u_mcu.acc(2'h1, 1'b0, {12'h0B0, OFS_SPACE_MAP}, q);
        check({oe, q}, {1'b1, SPACE_MAP_INIT});
        u_mcu.acc(2'h1, 1'b0, {12'h0B0, OFS_MEMCFG_A}, q);
        check(q, MEMCFG_A_VALUE);
        u_mcu.wr({8'hB0, OFS_MEMCFG_B}, 8'h00);
        u_mcu.acc(2'h1, 1'b0, {12'h0B0, OFS_MEMCFG_B}, q);
        check(q, MEMCFG_B_VALUE);
    endtask : t_reset

    task automatic t_prio();
        u_mcu.acc(2'h1, 1'b0, 20'h08400, q);
        check({sram, boot[0], prim[0]}, 3'h4);
        u_mcu.acc(2'h1, 1'b0, 20'h08800, q);
        check({sram, boot[0], prim[0]}, 3'h2);
        u_mcu.acc(2'h1, 1'b0, 20'h0A000, q);
        check(prim, 8'h00);
        u_mcu.acc(2'h2, 1'b0, 20'h0A000, q);
        check(prim, 8'h01);
        u_mcu.acc(2'h2, 1'b0, 20'h0C000, q);
        check(prim, 8'h02);
        u_mcu.acc(2'h2, 1'b0, 20'h08400, q);
        check({sram, boot[0]}, 2'h0);
        u_mcu.acc(2'h2, 1'b0, 20'h0B010, q);
        check({cfg, prim[0]}, 2'h2);
    endtask : t_prio

    task automatic t_page();
        u_mcu.wr({8'hB0, OFS_PAGE}, 8'hA5);
        check(pg, 8'hA5);
        u_mcu.acc(2'h1, 1'b0, {12'h0B0, OFS_PAGE}, q);
        check(q, 8'hA5);
        t_bus(16'hB0E0, 3'h5, 8'hA5);
        u_mcu.wr({8'hB0, OFS_PAGE}, 8'h3C);
        check(pg, 8'h3C);
    endtask : t_page

    task automatic t_map();
        u_mcu.wr({8'hB0, OFS_SPACE_MAP}, 8'h1C);
        u_mcu.acc(2'h1, 1'b0, 20'h0A000, q);
        check(prim[0], 1'b1);
        u_mcu.acc(2'h1, 1'b0, {12'h0B0, OFS_SPACE_MAP}, q);
        check(q, 8'h1C);
        u_mcu.wr({8'hB0, OFS_SPACE_MAP}, 8'h03);
        u_mcu.acc(2'h2, 1'b0, 20'h08400, q);
        check(sram, 1'b1);
        u_mcu.acc(2'h2, 1'b0, 20'h08800, q);
        check({boot[0], prim[0]}, 2'h2);
        u_mcu.wr({8'hB0, OFS_SPACE_MAP}, 8'h0C);
        u_mcu.acc(2'h1, 1'b0, 20'h0A000, q);
        check(prim[0], 1'b0);
    endtask : t_map

    task automatic t_ext();
        u_mcu.acc(2'h1, 1'b1, 20'h84000, q);
        check(sram, 1'b1);
        t_bus(16'h8400, 3'h5, 8'h3C);
    endtask : t_ext

    task automatic t_standby();
        repeat (10) @(negedge clk);
        check(stby, 1'b0);
        u_mcu.wr({8'hB0, OFS_PM0}, 8'h00);
        repeat (STANDBY_CYCLES) @(negedge clk);
        check(stby, 1'b0);
        @(negedge clk);
        check(stby, 1'b1);
        misc = ~misc;
        repeat (2) @(negedge clk);
        check(stby, 1'b0);
        u_mcu.acc(2'h0, 1'b0, 20'h0B0E0, q);
        t_bus(16'hB0E0, 3'h7, 8'h3C);
    endtask : t_standby

    // All five lines blocked: strobes idle high, reset and power-down low; reads still work.
    task automatic t_block();
        u_mcu.wr({8'hB0, OFS_PM2}, 8'h1F);
        u_mcu.acc(2'h1, 1'b0, {12'h0B0, OFS_PAGE}, q);
        check({bus[65:61], q}, {5'h1C, 8'h3C});
    endtask : t_block

    task automatic t_sel();
        u_mcu.acc(2'h0, 1'b0, 20'h0B100, q);
        check({tpe, per}, 3'h4);
        u_mcu.wr({8'hB0, OFS_PAGE}, 8'h00);
        u_mcu.acc(2'h0, 1'b0, 20'h0B100, q);
        check({tpe, per}, 3'h0);
        u_mcu.acc(2'h0, 1'b0, 20'h0B200, q);
        check({tpe, per}, 3'h1);
        u_mcu.acc(2'h0, 1'b0, 20'h0B300, q);
        check({tpe, per}, 3'h2);
    endtask : t_sel

    task automatic stop_test();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        #20000;
        errors++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        misc = 54'h1A_5C36_9E10_F1E3;
        errors = 0;
        tests_run = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_prio();
        t_page();
        t_map();
        t_ext();
        t_standby();
        t_block();
        t_sel();
        stop_test();
    end
endmodule : msd_memory_select_decode_test
`default_nettype wire
